//--- hdl/sbc_spi_wakeup_control.sv
// serial configuration port, status word and wake-up detection
`timescale 1ns/1ns
`include "sbc_regs.svh"
module sbc_spi_wakeup_control #(
	parameter int SWITCHES          = 8,
	parameter int DEBOUNCE_CYCLES   = `WAKE_DEBOUNCE_CYCLES,
	parameter int BUS_WAKE_CYCLES   = `BUS_WAKE_CYCLES,
	parameter int DETECT_MAX_CYCLES = `BUS_DETECT_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire logic                  chip_select_n,
	input  wire logic                  spi_sck,
	input  wire logic                  spi_mosi,
	output logic                       spi_miso,
	output logic                       spi_miso_oe_n,
	input  wire logic                  ignition_wake_input,
	input  wire logic                  bus_rx,
	input  wire logic                  vs_undervoltage,
	input  wire logic                  vcc_undervoltage,
	input  wire logic [SWITCHES-1:0]   switch_scan_pin,
	input  wire logic [SWITCHES-1:0]   switch_input_pin,
	input  wire logic [2:0]            overtemp_flags,
	input  wire logic [3:0]            monitor_flags,
	output logic                       interrupt_out_n,
	output logic [`WORD_BITS-1:0]      configuration_word,
	output logic                       mode_low_power,
	output logic                       mode_sleep,
	output logic                       bus_receiver_on,
	output logic [SWITCHES-1:0]        switch_source_on,
	output logic [SWITCHES-1:0]        switch_irq_enable
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int SW = 7 + 2 * SWITCHES;
	localparam int AW = $clog2(DETECT_MAX_CYCLES + 1);
	localparam logic [AW-1:0] DETECT_LAST = AW'(DETECT_MAX_CYCLES - 1);
	localparam logic [4:0] WORD_DONE = 5'h10;
	localparam int EVAL_CYC = `EVAL_GAP_CYCLES;

	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	wire  [SW-1:0] pin_in = {switch_input_pin, switch_scan_pin, vcc_undervoltage,
	                         vs_undervoltage, bus_rx, ignition_wake_input, spi_mosi,
	                         spi_sck, chip_select_n};

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			// idle pin levels, so no false edge follows reset
			sync1 <= {{(2 * SWITCHES){1'b0}}, 7'h11};
			sync2 <= {{(2 * SWITCHES){1'b0}}, 7'h11};
		end
		else
		begin
			sync1 <= pin_in;
			sync2 <= sync1;
		end
	end

	wire                cs_s     = sync2[0];
	wire                sck_s    = sync2[1];
	wire                mosi_s   = sync2[2];
	wire                ignition_wake_input_s   = sync2[3];
	wire                bus_s    = sync2[4];
	wire                vs_uv_s  = sync2[5];
	wire                vcc_uv_s = sync2[6];
	wire [SWITCHES-1:0] scan_s   = sync2[7 +: SWITCHES];
	wire [SWITCHES-1:0] comp_s   = sync2[7 + SWITCHES +: SWITCHES];

	// ------------------------------------------------------------
	// edges of the sampled pins
	// ------------------------------------------------------------
	logic               cs_q;
	logic               sck_q;
	logic               vs_uv_q;
	logic [SWITCHES-1:0] scan_q;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			cs_q    <= 1'b1;
			sck_q   <= 1'b0;
			vs_uv_q <= 1'b0;
			scan_q  <= '0;
		end
		else
		begin
			cs_q    <= cs_s;
			sck_q   <= sck_s;
			vs_uv_q <= vs_uv_s;
			scan_q  <= scan_s;
		end
	end

	wire cs_fell  = cs_q && !cs_s;
	wire cs_rose  = !cs_q && cs_s;
	wire sck_rise = sck_s && !sck_q;
	wire sck_fall = !sck_s && sck_q;

	// ------------------------------------------------------------
	// mode, configuration and status state
	// ------------------------------------------------------------
	sbc_types_pkg::mode_e    mode;
	sbc_types_pkg::mode_e    next_mode;
	sbc_types_pkg::irq_src_e irq_src;
	logic [`WORD_BITS-1:0]   cfg;
	logic [`WORD_BITS-1:0]   rx_shift;
	logic [`WORD_BITS-1:0]   status_snap;
	logic [4:0]              bit_cnt;
	logic                    accepted;
	logic                    miso_q;
	logic                    ignition_wake_input_armed;
	logic                    assess_done;
	logic [AW-1:0]           assess_cnt;
	logic [SWITCHES-1:0]     src_en;
	logic [SWITCHES-1:0]     int_ctrl;
	logic [SWITCHES-1:0]     irq_en;
	logic [SWITCHES-1:0]     sw_state;
	logic [SWITCHES-1:0]     sw_event;

	// ------------------------------------------------------------
	// serial engine: sample on rising, shift on falling sck
	// ------------------------------------------------------------
	wire next_accept = (mode != sbc_types_pkg::MODE_SLEEP) && !vcc_uv_s;
	wire xfer_on     = accepted && !cs_s;
	wire bit_room    = (bit_cnt != WORD_DONE);
	wire commit      = cs_rose && accepted && (bit_cnt == WORD_DONE);
	wire [3:0] out_idx = 4'hF - bit_cnt[3:0];

	wire [3:0] diag_hi = cfg[`CFG_DIV_OUT_EN] ? monitor_flags : {overtemp_flags, ignition_wake_input_s};
	wire [`WORD_BITS-1:0] status_word = {diag_hi, ~cfg[`CFG_WD_DIS], vs_uv_s,
	                                     irq_src, sw_state};

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			accepted    <= 1'b0;
			bit_cnt     <= 5'h00;
			rx_shift    <= `CFG_RESET;
			status_snap <= 16'h0000;
			miso_q      <= 1'b0;
		end
		else if (cs_fell)
		begin
			accepted    <= next_accept;
			bit_cnt     <= 5'h00;
			status_snap <= status_word;
			miso_q      <= status_word[15];
		end
		else if (cs_rose)
			accepted <= 1'b0;
		else if (xfer_on && bit_room)
		begin
			if (sck_rise)
			begin
				rx_shift <= {rx_shift[14:0], mosi_s};
				bit_cnt  <= bit_cnt + 5'h01;
			end
			else if (sck_fall)
				miso_q <= status_snap[out_idx];
		end
	end

	assign spi_miso      = miso_q;
	assign spi_miso_oe_n = !xfer_on;

	// ------------------------------------------------------------
	// ignition input: debounced rise, disarm on sleep command, re-arm after debounced low
	// ------------------------------------------------------------
	logic ignition_wake_input_fire;
	logic ignition_wake_input_low_held;

	wake_debounce #(.CYCLES(DEBOUNCE_CYCLES)) ignition_wake_input_high_deb (
		.mclk  (mclk),
		.rstn  (rstn),
		.level (ignition_wake_input_s),
		.run   (1'b1),
		.fired (ignition_wake_input_fire),
		.held  ()
	);

	wake_debounce #(.CYCLES(DEBOUNCE_CYCLES)) ignition_wake_input_low_deb (
		.mclk  (mclk),
		.rstn  (rstn),
		.level (!ignition_wake_input_s),
		.run   (1'b1),
		.fired (),
		.held  (ignition_wake_input_low_held)
	);

	wire sleep_cmd = commit && rx_shift[`CFG_SLEEP];
	wire ignition_wake_input_wake = ignition_wake_input_fire && ignition_wake_input_armed;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			ignition_wake_input_armed <= 1'b1;
		else if (sleep_cmd && ignition_wake_input_s)
			ignition_wake_input_armed <= 1'b0;
		else if (ignition_wake_input_low_held)
			ignition_wake_input_armed <= 1'b1;
	end

	// ------------------------------------------------------------
	// bus wake-up assessment while the transceiver is off
	// ------------------------------------------------------------
	logic bus_fire;
	wire  bus_watch = (mode != sbc_types_pkg::MODE_ACTIVE) && !cfg[`CFG_BUS_EN];
	wire  assessing = bus_watch && !bus_s && !assess_done;

	wake_debounce #(.CYCLES(BUS_WAKE_CYCLES)) bus_low_deb (
		.mclk  (mclk),
		.rstn  (rstn),
		.level (!bus_s),
		.run   (assessing),
		.fired (bus_fire),
		.held  ()
	);

	// a stuck-low bus must not keep the receiver powered
	always_ff @(posedge mclk)
	begin
		if (!rstn || !assessing)
			assess_cnt <= '0;
		else
			assess_cnt <= assess_cnt + 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn || !bus_watch || bus_s)
			assess_done <= 1'b0;
		else if (bus_fire || (assessing && assess_cnt == DETECT_LAST))
			assess_done <= 1'b1;
	end

	assign bus_receiver_on = assessing;

	// ------------------------------------------------------------
	// switch inputs, one slice per channel
	// ------------------------------------------------------------
	wire [2:0] prog_idx = rx_shift[`CFG_SW_ADDR_HI:`CFG_SW_ADDR_LO];
	wire       prog_now = commit && rx_shift[`CFG_SW_PROG];

	genvar i;
	generate
		for (i = 0; i < SWITCHES; i++)
		begin : g_switch
			wire hit      = prog_now && (prog_idx == 3'(i));
			wire scan_end = scan_q[i] && !scan_s[i];
			wire ext_on   = src_en[i] && !int_ctrl[i];
			assign switch_source_on[i] = src_en[i] && (int_ctrl[i] || scan_s[i]);
			assign sw_event[i] = scan_end && ext_on && irq_en[i]
			                     && (comp_s[i] != sw_state[i]);
			always_ff @(posedge mclk)
			begin
				if (!rstn)
				begin
					src_en[i]   <= 1'b0;
					int_ctrl[i] <= 1'b0;
					irq_en[i]   <= 1'b0;
				end
				else if (hit)
				begin
					src_en[i]   <= rx_shift[`CFG_SW_SRC_EN];
					int_ctrl[i] <= rx_shift[`CFG_SW_INT_CTRL];
					irq_en[i]   <= rx_shift[`CFG_SW_IRQ_EN];
				end
			end
			always_ff @(posedge mclk)
			begin
				if (!rstn)
					sw_state[i] <= 1'b0;
				else if ((scan_end && ext_on) || (src_en[i] && int_ctrl[i]))
					sw_state[i] <= comp_s[i];
			end
			switch_latch_a: assert property (@(posedge mclk) disable iff (!rstn)
				scan_end && ext_on |=> sw_state[i] == $past(comp_s[i]))
				else $error("switch state not latched on scan fall");
		end
	endgenerate

	assign switch_irq_enable = irq_en;

	// ------------------------------------------------------------
	// operating mode
	// ------------------------------------------------------------
	wire lp_ok      = !cfg[`CFG_BUS_EN] && cfg[`CFG_WD_DIS] && !cfg[`CFG_SLEEP] && cs_s;
	wire sleep_wake = (mode == sbc_types_pkg::MODE_SLEEP) && (ignition_wake_input_wake || bus_fire);

	always_comb
	begin
		next_mode = mode;
		case (mode)
			sbc_types_pkg::MODE_ACTIVE:
				if (sleep_cmd)
					next_mode = sbc_types_pkg::MODE_SLEEP;
				else if (lp_ok)
					next_mode = sbc_types_pkg::MODE_LOW_POWER;
			sbc_types_pkg::MODE_LOW_POWER:
				if (!lp_ok)
					next_mode = sbc_types_pkg::MODE_ACTIVE;
			sbc_types_pkg::MODE_SLEEP:
				if (sleep_wake)
					next_mode = sbc_types_pkg::MODE_ACTIVE;
			default:
				next_mode = sbc_types_pkg::MODE_ACTIVE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			mode <= sbc_types_pkg::MODE_ACTIVE;
		else
			mode <= next_mode;
	end

	// the sleep request drops on wake so the part does not fall straight back
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			cfg <= `CFG_RESET;
		else if (commit)
			cfg <= rx_shift;
		else if (sleep_wake)
			cfg[`CFG_SLEEP] <= 1'b0;
	end

	assign configuration_word = cfg;
	assign mode_low_power     = (mode == sbc_types_pkg::MODE_LOW_POWER);
	assign mode_sleep         = (mode == sbc_types_pkg::MODE_SLEEP);

	// ------------------------------------------------------------
	// interrupt source and output; a new event beats the readout clear
	// ------------------------------------------------------------
	wire power_event = vs_uv_s && !vs_uv_q && (mode != sbc_types_pkg::MODE_SLEEP);
	wire event_any   = bus_fire || ignition_wake_input_wake || (|sw_event) || power_event;

	sbc_types_pkg::irq_src_e event_src;
	assign event_src = bus_fire  ? sbc_types_pkg::IRQ_BUS :
	                   ignition_wake_input_wake ? sbc_types_pkg::IRQ_IGNITION :
	                   (|sw_event) ? sbc_types_pkg::IRQ_SWITCH :
	                   sbc_types_pkg::IRQ_POWER;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			irq_src         <= sbc_types_pkg::IRQ_POWER;
			interrupt_out_n <= 1'b1;
		end
		else if (event_any)
		begin
			irq_src         <= event_src;
			interrupt_out_n <= 1'b0;
		end
		else if (commit)
		begin
			irq_src         <= sbc_types_pkg::IRQ_POWER;
			interrupt_out_n <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	miso_idle_a: assert property (cs_s |-> spi_miso_oe_n)
		else $error("serial output driven while deselected");
	short_word_a: assert property (cs_rose && bit_cnt != WORD_DONE |=> cfg == $past(cfg))
		else $error("configuration taken from incomplete word");
	cfg_commit_a: assert property (commit |=> cfg == $past(rx_shift))
		else $error("received word not committed");
	cfg_apply_a: assert property (commit && !rx_shift[`CFG_BUS_EN] |-> ##[1:EVAL_CYC] !cfg[`CFG_BUS_EN])
		else $error("configuration not applied in evaluation gap");
	first_bit_a: assert property (cs_fell && next_accept |=> spi_miso == $past(status_word[15]))
		else $error("first bit is not status bit 15");
	uv_refuse_a: assert property (cs_fell && vcc_uv_s |=> spi_miso_oe_n [*3])
		else $error("transfer accepted in undervoltage");
	lp_entry_a: assert property ($rose(mode_low_power) |-> $past(lp_ok))
		else $error("low-power entered with blocker active");
	bus_wake_a: assert property (bus_fire |=> !interrupt_out_n && irq_src == sbc_types_pkg::IRQ_BUS)
		else $error("bus wake not signalled");
	assess_end_a: assert property (assessing |-> assess_cnt <= DETECT_LAST)
		else $error("bus assessment overran its limit");
	lp_stay_a: assert property (mode_low_power && lp_ok && (bus_fire || ignition_wake_input_wake) |=> mode_low_power)
		else $error("wake-up left low-power mode");
	cs_wake_a: assert property (mode_low_power && !cs_s |=> mode == sbc_types_pkg::MODE_ACTIVE)
		else $error("chip select did not wake the device");
	ignition_wake_input_wake_a: assert property (ignition_wake_input_wake && !bus_fire |=> !interrupt_out_n && irq_src == sbc_types_pkg::IRQ_IGNITION)
		else $error("ignition wake not signalled");
	ignition_wake_input_arm_a: assert property (sleep_cmd && ignition_wake_input_s |=> !ignition_wake_input_armed)
		else $error("ignition wake not disarmed");
	switch_gate_a: assert property ((sw_event & ~(src_en & irq_en)) == '0)
		else $error("switch event from disabled input");
	irq_hold_a: assert property (!interrupt_out_n && !commit |=> !interrupt_out_n)
		else $error("interrupt released before readout");
	irq_clear_a: assert property (commit && !event_any |=> interrupt_out_n && irq_src == sbc_types_pkg::IRQ_POWER)
		else $error("interrupt source not cleared on readout");

	word_cover_c:   cover property (commit);
	bus_cover_c:    cover property (mode_low_power && bus_fire);
	sleep_cover_c:  cover property (mode_sleep ##1 sleep_wake);
	switch_cover_c: cover property (|sw_event);
endmodule

//--- hdl/sbc_regs.svh
// constants of the serial configuration and wake-up block
// What this block does
// - debounced ignition rise wakes, pulls interrupt low
// - after sleep command, ignition needs debounced low
// - wake-up source readable in status word
// - source codes power/switch/ignition/bus, cleared on readout
// - low-power only with bus, watchdog, serial idle
// - scan rise enables source, fall latches switch
// - switch change interrupts only when enabled
// - disabled current source never wakes
// - bus low long enough drops interrupt output
// - bus assessment ends by its maximum time
// - after bus/ignition wake stay in low-power
// - debounced ignition high in low-power interrupts
// - chip select wakes; unchanged config returns low-power
// - no transfer accepted if select falls during logic supply undervoltage
// - polarity/phase 0/0 and 1/1 both work
// - deselected: ignore clock, output high impedance
// - words shift most significant bit first
// - sixteen received bits form configuration word
// - status shows configuration from previous transfer
// - commit only on deselect after sixteen clocks
// - new configuration applied within evaluation gap
// - upper configuration bits, all reset zero
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

`define WORD_BITS        16
`define CFG_RESET        16'h0000
`define CFG_BUS_HS       15
`define CFG_TX_TO_DIS    14
`define CFG_REF_MUL      13
`define CFG_BUS_EN       12
`define CFG_SLEEP        11
`define CFG_DIV_OUT_EN   10
`define CFG_DIV_SRC      9
`define CFG_SW_PROG      8
`define CFG_SW_ADDR_HI   7
`define CFG_SW_ADDR_LO   5
`define CFG_SW_SRC_EN    4
`define CFG_SW_INT_CTRL  2
`define CFG_SW_IRQ_EN    1
`define CFG_WD_DIS       0

`define CLK_PERIOD_NS        10
`define WAKE_DEBOUNCE_NS     100000
`define BUS_WAKE_NS          80000
`define BUS_DETECT_MAX_NS    150000
`define EVAL_GAP_NS          1000
`define WAKE_DEBOUNCE_CYCLES ((`WAKE_DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_WAKE_CYCLES      ((`BUS_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_DETECT_CYCLES    (`BUS_DETECT_MAX_NS / `CLK_PERIOD_NS)
`define EVAL_GAP_CYCLES      (`EVAL_GAP_NS / `CLK_PERIOD_NS)

`endif

//--- hdl/sbc_types_pkg.sv
// types shared by the serial configuration and wake-up block
package sbc_types_pkg;
	typedef enum logic [1:0] {
		MODE_ACTIVE    = 2'b00,
		MODE_LOW_POWER = 2'b01,
		MODE_SLEEP     = 2'b10
	} mode_e;
	typedef enum logic [1:0] {
		IRQ_POWER    = 2'b00,
		IRQ_SWITCH   = 2'b01,
		IRQ_IGNITION = 2'b10,
		IRQ_BUS      = 2'b11
	} irq_src_e;
endpackage

//--- hdl/wake_debounce.sv
// level debouncer: fires once a level has stood for a set number of cycles
`timescale 1ns/1ns
module wake_debounce #(
	parameter int CYCLES = 16
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic level,
	input  wire logic run,
	output logic      fired,
	output logic      held
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	localparam logic [CW-1:0] FULL = CW'(CYCLES);

	logic [CW-1:0] cnt;
	wire           counting = level && run;

	assign fired = counting && (cnt == LAST);
	assign held  = counting && (cnt == FULL);

	always_ff @(posedge mclk)
	begin
		if (!rstn || !counting)
			cnt <= '0;
		else if (cnt != FULL)
			cnt <= cnt + 1'b1;
	end
endmodule

//--- verification/spi_host.sv
// serial master model that drives the configuration port
`timescale 1ns/1ns
`include "sbc_regs.svh"
module spi_host (
	input  wire logic mclk,
	input  wire logic spi_miso,
	input  wire logic spi_miso_oe_n,
	output logic      chip_select_n,
	output logic      spi_sck,
	output logic      spi_mosi
);
	// ----------------------------------------
	// one transfer, 125 ns clock period
	// ----------------------------------------
	initial
	begin
		chip_select_n = 1'b1;
		spi_sck       = 1'b0;
		spi_mosi      = 1'b0;
	end

	task automatic xfer(input logic [15:0] tx, input int nbits, input logic clock_polarity,
		output logic [15:0] rx, output logic drove);
		int i;
	begin
		rx    = 16'h0000;
		drove = 1'b1;
		@(posedge mclk);
		#3;
		// idle level settles before select so no stray edge is seen
		spi_sck <= clock_polarity;
		#63;
		chip_select_n <= 1'b0;
		for (i = 0; i < nbits; i++)
		begin
			#62;
			spi_sck  <= 1'b0;
			spi_mosi <= tx[15-i];
			#63;
			spi_sck <= 1'b1;
			rx      = {rx[14:0], spi_miso};
			drove   = drove & ~spi_miso_oe_n;
		end
		#62;
		spi_sck <= clock_polarity;
		#63;
		chip_select_n <= 1'b1;
		// released data line shows the inverse, never a stale value
		spi_mosi <= ~spi_mosi;
		repeat (`EVAL_GAP_CYCLES) @(posedge mclk);
	end
	endtask
endmodule

//--- verification/sbc_spi_wakeup_control_test.sv
// testbench for the serial configuration and wake-up block
`timescale 1ns/1ns
module sbc_spi_wakeup_control_test;
	localparam int DEB = 20;
	localparam int BW  = 10;
	localparam int DM  = 30;
	localparam logic [15:0] SW_WORD [3] = '{16'h0112, 16'h0122, 16'h0150};
	localparam logic [2:0]  SW_SRC  = 3'b101;
	localparam logic [2:0]  SW_IRQ  = 3'b011;

	logic        mclk;
	logic        rstn;
	logic        chip_select_n;
	logic        spi_sck;
	logic        spi_mosi;
	logic        spi_miso;
	logic        spi_miso_oe_n;
	logic        ignition_wake_input;
	logic        bus_rx;
	logic        vs_undervoltage;
	logic        vcc_undervoltage;
	logic [7:0]  switch_scan_pin;
	logic [7:0]  switch_input_pin;
	logic [2:0]  overtemp_flags;
	logic [3:0]  monitor_flags;
	logic        interrupt_out_n;
	logic [15:0] configuration_word;
	logic        mode_low_power;
	logic        mode_sleep;
	logic        bus_receiver_on;
	logic [7:0]  switch_source_on;
	logic [7:0]  switch_irq_enable;
	logic [15:0] rx;
	logic        dr;
	logic        clock_polarity;
	int          fails;
	int          cmp_count;

	sbc_spi_wakeup_control #(
		.DEBOUNCE_CYCLES   (DEB),
		.BUS_WAKE_CYCLES   (BW),
		.DETECT_MAX_CYCLES (DM)
	) DUT (
		.mclk, .rstn, .chip_select_n, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe_n,
		.ignition_wake_input, .bus_rx, .vs_undervoltage, .vcc_undervoltage,
		.switch_scan_pin, .switch_input_pin, .overtemp_flags, .monitor_flags,
		.interrupt_out_n, .configuration_word, .mode_low_power, .mode_sleep,
		.bus_receiver_on, .switch_source_on, .switch_irq_enable
	);

	spi_host host (
		.mclk, .spi_miso, .spi_miso_oe_n, .chip_select_n, .spi_sck, .spi_mosi
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic wrap_up;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	// one ns late so the edge's register updates have landed
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
	begin
		#1;
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic xf(input logic [15:0] tx);
		host.xfer(tx, 16, clock_polarity, rx, dr);
	endtask

	task automatic wait_irq(input int n);
		int k;
	begin
		k = 0;
		while (interrupt_out_n !== 1'b0 && k < n)
		begin
			@(posedge mclk);
			k++;
		end
		if (interrupt_out_n !== 1'b0)
		begin
			fails++;
			wrap_up;
		end
	end
	endtask

	initial
	begin
		repeat (90000) @(posedge mclk);
		fails++;
		wrap_up;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		fails = 0;
		cmp_count = 0;
		clock_polarity = 1'b0;
		rstn = 1'b0;
		ignition_wake_input = 1'b0;
		bus_rx = 1'b1;
		vs_undervoltage = 1'b0;
		vcc_undervoltage = 1'b0;
		switch_scan_pin = 8'h00;
		switch_input_pin = 8'h00;
		overtemp_flags = 3'h5;
		monitor_flags = 4'h6;
		tick(12);
		rstn <= 1'b1;
		chk("cfg reset", configuration_word, 16'h0000);
		chk("irq idle", interrupt_out_n, 1'b1);
		chk("miso idle", spi_miso_oe_n, 1'b1);
		tick(3);
		xf(16'hE6A4);
		chk("status", rx[15:8], 8'hA8);
		chk("cfg word", configuration_word, 16'hE6A4);
		xf(16'h0001);
		chk("status div", rx[15:8], 8'h68);
		chk("low power", mode_low_power, 1'b1);
		for (int p = 0; p < 2; p++)
		begin
			clock_polarity = p[0];
			xf(16'h0001);
			chk("poll", rx[15:8], 8'hA0);
			chk("back low power", mode_low_power, 1'b1);
		end
		clock_polarity = 1'b0;
		xf(16'h1001);
		chk("bus enabled", mode_low_power, 1'b0);
		xf(16'h0001);
		host.xfer(16'h0800, 8, clock_polarity, rx, dr);
		chk("short word", configuration_word, 16'h0001);
		chk("short sleep", mode_sleep, 1'b0);
		// bus held dominant in low-power
		bus_rx <= 1'b0;
		wait_irq(BW + 10);
		chk("bus wake", interrupt_out_n, 1'b0);
		tick(DM);
		chk("assess end", bus_receiver_on, 1'b0);
		chk("stay low power", mode_low_power, 1'b1);
		bus_rx <= 1'b1;
		tick(5);
		xf(16'h0001);
		chk("bus source", rx[9:8], 2'b11);
		chk("irq released", interrupt_out_n, 1'b1);
		xf(16'h0001);
		chk("source cleared", rx[9:8], 2'b00);
		// too short a pulse, then a debounced rise
		ignition_wake_input <= 1'b1;
		tick(DEB / 2);
		ignition_wake_input <= 1'b0;
		tick(DEB * 2);
		chk("short pulse", interrupt_out_n, 1'b1);
		ignition_wake_input <= 1'b1;
		wait_irq(DEB + 10);
		chk("ign low power", mode_low_power, 1'b1);
		xf(16'h0800);
		chk("ign source", rx[15:8], 8'hB2);
		chk("sleep", mode_sleep, 1'b1);
		// short low, then a long high: a fresh rise that must not wake
		ignition_wake_input <= 1'b0;
		tick(DEB / 2);
		ignition_wake_input <= 1'b1;
		tick(DEB * 2);
		chk("disarmed", mode_sleep, 1'b1);
		ignition_wake_input <= 1'b0;
		tick(DEB + 5);
		ignition_wake_input <= 1'b1;
		wait_irq(DEB + 10);
		chk("sleep exit", mode_sleep, 1'b0);
		xf(16'h0000);
		chk("wake source", rx[15:8], 8'hBA);
		// enabled, source off, interrupt off
		for (int s = 0; s < 3; s++)
		begin
			xf(SW_WORD[s]);
			switch_scan_pin[s] <= 1'b1;
			tick(5);
			switch_input_pin[s] <= 1'b1;
			chk("source on", switch_source_on[s], SW_SRC[s]);
			chk("irq enable", switch_irq_enable[s], SW_IRQ[s]);
			tick(5);
			switch_scan_pin[s] <= 1'b0;
			tick(5);
			chk("switch irq", interrupt_out_n, s != 0);
			xf(16'h0000);
			chk("switch source", rx[9:8], (s == 0) ? 2'b01 : 2'b00);
		end
		vcc_undervoltage <= 1'b1;
		tick(5);
		xf(16'h1234);
		chk("uv refused", dr, 1'b0);
		chk("uv cfg", configuration_word, 16'h0000);
		vcc_undervoltage <= 1'b0;
		tick(5);
		xf(16'h0000);
		chk("uv over", dr, 1'b1);
		wrap_up;
	end
endmodule
